// *** acpr_device.sv ***
// Purpose: converter end: start, power down, reset pin, parallel output
// Assumes: sample_i holds the analog result in straight binary
// Notes:   all link inputs pass a two-flop synchroniser first
//
// Chosen here: the cfg_wr_i register that takes over from the power down pin, and impulse mode.
`timescale 1ns/1ps
`default_nettype none
module acpr_device #(
  parameter int CONV_LEN = acpr_pkg::CONV_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  acpr_link_if.dev                       link,
  input  wire logic [acpr_pkg::DATA_W-1:0] sample_i,
  input  wire logic                      impulse_mode_i,
  input  wire logic                      cfg_wr_i,
  input  wire logic                      cfg_pd_i,
  output logic                           conv_done_o,
  output logic                           low_power_o,
  output logic                           temp_en_o,
  output logic                           ref_en_o,
  output logic                           buf_en_o,
  output logic                           serial_mode_o
);
  import acpr_pkg::*;

  logic [DEV_IN_W-1:0] pins;
  logic                cnv_n;
  logic                cs_n;
  logic                rd_n;
  logic                rst_pin;
  logic                pd_pin;
  logic                coding;
  logic                spp;
  logic                refpd;
  logic                bufpd;
  logic                cnv_n_prev_q;
  logic                rst_prev_q;
  logic                start_fall;
  logic                rst_fall;
  logic                pd_eff;
  logic                conv_end;
  logic [CNT_W-1:0]    cnt_q;
  logic                cfg_sel_q;
  logic                cfg_pd_q;
  logic [DATA_W-1:0]   result_q;
  logic                busy_q;
  logic                oe_q;
  acpr_dev_state_type  state_q;
  acpr_dev_state_type  state_d;

  // every pin is asynchronous to this clock
  acpr_sync #(
    .W       (DEV_IN_W),
    .RST_VAL (DEV_IN_RST)
  ) acpr_sync_inst (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.conversion_start_n, link.cs_n, link.rd_n,
             link.reset_pin, link.power_down_pin,
             link.output_coding_select, link.serial_parallel_select,
             link.reference_powerdown, link.refbuffer_powerdown}),
    .q_o   (pins)
  );

  // unpack synchronised pins
  assign {cnv_n, cs_n, rd_n, rst_pin, pd_pin,
          coding, spp, refpd, bufpd} = pins;

  // edge history of the strobe and the reset pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnv_n_prev_q <= 1'b1;
      rst_prev_q   <= 1'b0;
    end else begin
      cnv_n_prev_q <= cnv_n;
      rst_prev_q   <= rst_pin;
    end
  end

  assign start_fall = cnv_n_prev_q & ~cnv_n;
  assign rst_fall   = rst_prev_q & ~rst_pin;
  // register bit takes over from the pin once software used it
  assign pd_eff     = cfg_sel_q ? cfg_pd_q : pd_pin;
  assign conv_end   = (cnt_q == CNT_W'(CONV_LEN - 1));

  // conversion sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DEV_ACQ: begin
        if (rst_pin) begin
          state_d = DEV_RST;
        end else if (start_fall && !pd_eff) begin
          // cs and rd play no part here
          state_d = DEV_CONV;
        end
      end
      DEV_CONV: begin
        if (rst_pin) begin
          state_d = DEV_RST;
        end else if (conv_end) begin
          // new strobes and power down are not looked at
          state_d = DEV_ACQ;
        end
      end
      DEV_RST: begin
        if (!rst_pin) begin
          state_d = DEV_ACQ;
        end
      end
      default: state_d = DEV_ACQ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DEV_ACQ;
    end else begin
      state_q <= state_d;
    end
  end

  // conversion length counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != DEV_CONV) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // busy follows the conversion phase; its fall marks a fresh result unless the reset pin cut the conversion short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q      <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      busy_q      <= (state_d == DEV_CONV);
      conv_done_o <= (state_q == DEV_CONV) && conv_end && !rst_pin;
    end
  end

  // configuration register, cleared by the reset pin release
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_fall) begin
      cfg_sel_q <= 1'b0;
      cfg_pd_q  <= 1'b0;
    end else if (cfg_wr_i) begin
      cfg_sel_q <= 1'b1;
      cfg_pd_q  <= cfg_pd_i;
    end
  end

  // result latch; coding chosen at the end of each conversion
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_fall) begin
      result_q <= '0;
    end else if (state_q == DEV_CONV && conv_end && !rst_pin) begin
      if (coding) begin
        result_q <= sample_i;
      end else begin
        result_q <= {~sample_i[MSB_POS], sample_i[MSB_POS-1:0]};
      end
    end
  end

  // output enable; power down leaves the bus interface working
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
    end else begin
      // cs/rd tied low gives continuous drive of each result
      oe_q <= !cs_n && !rd_n && !spp && !rst_pin;
    end
  end

  // supply and reference controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_power_o <= 1'b0;
      ref_en_o    <= 1'b0;
      buf_en_o    <= 1'b0;
      temp_en_o   <= 1'b0;
    end else begin
      // impulse mode idles only between conversions
      low_power_o <= (state_d != DEV_CONV) &&
                     (pd_eff || impulse_mode_i);
      ref_en_o    <= !refpd;
      buf_en_o    <= !bufpd;
      temp_en_o   <= !refpd && !bufpd;
    end
  end

  // serial port itself lives elsewhere; only the hand-over is here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_o <= 1'b0;
    end else begin
      serial_mode_o <= spp;
    end
  end

  assign link.busy     = busy_q;
  assign link.data_out = result_q;
  assign link.data_oe  = oe_q;
endmodule : acpr_device
`default_nettype wire

// *** acpr_pkg.sv ***
// Purpose: shared constants and types of the converter control pair
// Assumes: one 25 MHz clock on both ends
// Notes:   offsets are byte addresses on the host register bus
package acpr_pkg;
  localparam int DATA_W           = 14;
  localparam int MSB_POS          = DATA_W - 1;
  localparam int CLK_PERIOD_NS    = 40;
  // conversion phase length
  localparam int CONV_TIME_NS     = 1000;
  localparam int CONV_CYCLES      =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // low time of the host start strobe
  localparam int START_LOW_NS     = 120;
  localparam int START_LOW_CYCLES =
    (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_WAIT_CYCLES = 16;
  localparam int READ_WAIT_CYCLES = 8;
  localparam int CNT_W            = 8;
  // link input bundle at the device, reset value of its synchroniser
  localparam int DEV_IN_W         = 9;
  localparam logic [DEV_IN_W-1:0] DEV_IN_RST = 9'h1c0;
  // host registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam int CTRL_START  = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_CODING = 2;
  localparam int CTRL_PD     = 3;
  localparam int CTRL_RESET  = 4;
  localparam int CTRL_REFPD  = 5;
  localparam int CTRL_BUFPD  = 6;
  localparam int CTRL_SERIAL = 7;
  localparam logic [7:0] CTRL_RST_VAL = 8'h00;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_NEW    = 1;
  localparam int STAT_ACTIVE = 2;
  typedef enum logic [2:0] {
    DEV_ACQ  = 3'b001,
    DEV_CONV = 3'b010,
    DEV_RST  = 3'b100
  } acpr_dev_state_type;
  typedef enum logic [4:0] {
    H_IDLE   = 5'b00001,
    H_START  = 5'b00010,
    H_WAITHI = 5'b00100,
    H_WAITLO = 5'b01000,
    H_READ   = 5'b10000
  } acpr_host_state_type;
endpackage : acpr_pkg

// *** acpr_link_if.sv ***
// Purpose: pins between converter and host
// Assumes: data pins resolved here from the enable
// Notes:   no clocking block; both ends sample through synchronisers
`timescale 1ns/1ps
`default_nettype none
interface acpr_link_if;
  import acpr_pkg::*;
  logic              conversion_start_n;
  logic              cs_n;
  logic              rd_n;
  logic              reset_pin;
  logic              power_down_pin;
  logic              output_coding_select;
  logic              serial_parallel_select;
  logic              reference_powerdown;
  logic              refbuffer_powerdown;
  logic              busy;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;
  wire  [DATA_W-1:0] data_bus;
  // released bus shows the inverse, so a sample taken too early reads wrong
  assign data_bus = data_oe ? data_out : ~data_out;
  modport dev (
    input  conversion_start_n, cs_n, rd_n, reset_pin, power_down_pin,
           output_coding_select, serial_parallel_select,
           reference_powerdown, refbuffer_powerdown,
    output busy, data_out, data_oe
  );
  modport host (
    output conversion_start_n, cs_n, rd_n, reset_pin, power_down_pin,
           output_coding_select, serial_parallel_select,
           reference_powerdown, refbuffer_powerdown,
    input  busy, data_bus
  );
endinterface : acpr_link_if
`default_nettype wire

// *** acpr_sync.sv ***
// Purpose: two-flop synchroniser for a bundle of pin inputs
// Assumes: each bit is a level; multi-bit words must be stable when used
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module acpr_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // two stages against metastability
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : acpr_sync
`default_nettype wire

// *** acpr_host.sv ***
// Purpose: controller end: starts conversions and reads parallel results
// Assumes: software drives it over classic Wishbone, one word per register
// Notes:   reads each result after busy falls; outside master mode, never during conversion
`timescale 1ns/1ps
`default_nettype none
module acpr_host (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  acpr_link_if.host                      link
);
  import acpr_pkg::*;

  logic [7:0]          ctrl_q;
  logic                start_req_q;
  logic                new_q;
  logic [DATA_W-1:0]   result_q;
  logic [CNT_W-1:0]    cnt_q;
  logic                cnv_n_q;
  logic                sel_n_q;
  logic                busy_s;
  logic [DATA_W-1:0]   data_s;
  logic                req;
  logic                wr;
  logic                take;
  logic                grab;
  acpr_host_state_type state_q;

  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = req && wb_we_i;
  assign take = (state_q == H_IDLE) && start_req_q;
  assign grab = (state_q == H_READ) &&
                (cnt_q == CNT_W'(READ_WAIT_CYCLES - 1));

  acpr_sync #(
    .W       (1 + DATA_W),
    .RST_VAL ('0)
  ) acpr_sync_inst (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.busy, link.data_bus}),
    .q_o   ({busy_s, data_s})
  );

  // bus slave: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      unique case (wb_adr_i)
        REG_CTRL:   wb_dat_o <= {24'h000000, ctrl_q};
        REG_STATUS: wb_dat_o <= {29'h00000000, state_q != H_IDLE,
                                 new_q, busy_s};
        REG_RESULT: wb_dat_o <= {{(32-DATA_W){1'b0}}, result_q};
        default:    wb_dat_o <= '0;
      endcase
    end
  end

  // control bits; start self clears into a pending request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q      <= CTRL_RST_VAL;
      start_req_q <= 1'b0;
    end else begin
      if (wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        ctrl_q      <= wb_dat_i[7:0] & 8'hfe;
        // a start taken in this cycle must not stay pending
        start_req_q <= (start_req_q && !take) || wb_dat_i[CTRL_START];
      end else if (take) begin
        start_req_q <= 1'b0;
      end
    end
  end

  // new-result flag: set wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      new_q <= 1'b0;
    end else if (grab) begin
      new_q <= 1'b1;
    end else if (wr && wb_adr_i == REG_STATUS && wb_sel_i[0] &&
                 wb_dat_i[STAT_NEW]) begin
      new_q <= 1'b0;
    end
  end

  // transfer sequencer; wait for busy to rise bounded in case the start was ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= H_IDLE;
      cnt_q   <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      unique case (state_q)
        H_IDLE: begin
          cnt_q <= '0;
          if (take) state_q <= H_START;
        end
        H_START: if (cnt_q == CNT_W'(START_LOW_CYCLES - 1)) begin
          state_q <= H_WAITHI;
          cnt_q   <= '0;
        end
        H_WAITHI: begin
          if (busy_s) state_q <= H_WAITLO;
          else if (cnt_q == CNT_W'(BUSY_WAIT_CYCLES - 1)) state_q <= H_IDLE;
        end
        H_WAITLO: begin
          cnt_q <= '0;
          // read after convert keeps the bus quiet while converting, except in master mode where select and read stay low
          if (!busy_s) state_q <= H_READ;
        end
        H_READ: if (grab) state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // strobe, read window and result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnv_n_q  <= 1'b1;
      sel_n_q  <= 1'b1;
      result_q <= '0;
    end else begin
      cnv_n_q <= (state_q != H_START);
      // registered so select and read never glitch on the pins
      sel_n_q <= !(ctrl_q[CTRL_MASTER] ||
                   ((state_q == H_READ) && !grab));
      if (grab) result_q <= data_s;
    end
  end

  // master mode ties select and read low; no other driver shares it
  assign link.cs_n   = sel_n_q;
  assign link.rd_n   = sel_n_q;
  assign link.conversion_start_n     = cnv_n_q;
  assign link.reset_pin              = ctrl_q[CTRL_RESET];
  assign link.power_down_pin         = ctrl_q[CTRL_PD];
  assign link.output_coding_select   = ctrl_q[CTRL_CODING];
  assign link.serial_parallel_select = ctrl_q[CTRL_SERIAL];
  assign link.reference_powerdown    = ctrl_q[CTRL_REFPD];
  assign link.refbuffer_powerdown    = ctrl_q[CTRL_BUFPD];
endmodule : acpr_host
`default_nettype wire

// *** acpr_link_sva.sv ***
// Purpose: link checks between host end and converter end
// Assumes: one clock, synchronous active high reset
// Notes:   pin-to-effect delays include the two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module acpr_link_sva #(
  parameter int CONV_LEN = 4
) (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        conversion_start_n,
  input wire logic                        cs_n,
  input wire logic                        rd_n,
  input wire logic                        reset_pin,
  input wire logic                        serial_parallel_select,
  input wire logic                        busy,
  input wire logic [acpr_pkg::DATA_W-1:0] data_out,
  input wire logic                        data_oe
);
  import acpr_pkg::*;
  logic       rd_ok;
  logic [7:0] busy_cnt_q;
  // every condition that lets the converter drive the bus
  assign rd_ok = !cs_n && !rd_n && !serial_parallel_select && !reset_pin;
  // busy length counted, a repetition cannot take a parameter
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  oe_gate_a : assert property (
    data_oe |-> $past(rd_ok, 3)) else $error("bus driven while not read");
  oe_on_a : assert property (
    rd_ok [*4] |=> data_oe) else $error("bus not driven while read");
  start_busy_a : assert property (
    $rose(busy) |-> $past(conversion_start_n, 4)
                    && !$past(conversion_start_n, 3))
    else $error("busy rose without start strobe fall");
  busy_len_a : assert property (
    $fell(busy) |-> busy_cnt_q == 8'(CONV_LEN) || $past(reset_pin, 3)
                    || $past(reset_pin, 4)) else $error("conversion cut short");
  busy_max_a : assert property (
    busy |-> busy_cnt_q < 8'(CONV_LEN)) else $error("conversion too long");
  rst_abort_a : assert property (
    reset_pin [*4] |-> !busy && !data_oe) else $error("reset pin no abort");
  rst_clear_a : assert property (
    $fell(reset_pin) |-> ##[1:6] data_out == '0)
    else $error("result not cleared by reset pin");
  serial_off_a : assert property (
    serial_parallel_select [*4] |-> !data_oe)
    else $error("bus driven in serial mode");
  strobe_width_a : assert property (
    $fell(conversion_start_n) |-> !conversion_start_n [*3]
                                  ##1 conversion_start_n)
    else $error("start strobe width wrong");
  read_idle_a : assert property (
    $fell(rd_n) |-> !busy) else $error("read began during conversion");
endmodule : acpr_link_sva
`default_nettype wire

// *** adc_conversion_parallel_read_tb.sv ***
// Purpose: host and converter ends joined, driven over Wishbone
// Assumes: short conversion length so runs stay brief
// Notes:   expected results derive from the sample and coding choice
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_parallel_read_tb;
  import acpr_pkg::*;
  // long enough that a reset pin write lands inside a conversion
  localparam int CLEN = 12;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [13:0] smp = 14'h0000;
  logic        imp = 1'b0, cfg_wr = 1'b0, cfg_pd = 1'b0;
  logic        done, lowp, temp_en, ref_en, buf_en, ser;
  int          bad_count = 0;
  int          n_tests = 0;
  int          done_count = 0;
  acpr_link_if lnk ();
  acpr_host acpr_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(lnk));
  acpr_device #(.CONV_LEN(CLEN)) acpr_device_inst (.clk_i(clk_i),
    .rst_i(rst_i), .link(lnk), .sample_i(smp), .impulse_mode_i(imp),
    .cfg_wr_i(cfg_wr), .cfg_pd_i(cfg_pd), .conv_done_o(done),
    .low_power_o(lowp), .temp_en_o(temp_en), .ref_en_o(ref_en),
    .buf_en_o(buf_en), .serial_mode_o(ser));
  acpr_link_sva #(.CONV_LEN(CLEN)) acpr_link_sva_inst (.clk_i(clk_i),
    .rst_i(rst_i), .conversion_start_n(lnk.conversion_start_n),
    .cs_n(lnk.cs_n), .rd_n(lnk.rd_n), .reset_pin(lnk.reset_pin),
    .serial_parallel_select(lnk.serial_parallel_select),
    .busy(lnk.busy), .data_out(lnk.data_out), .data_oe(lnk.data_oe));
  always #20 clk_i = ~clk_i;
  // completed conversions, one pulse each
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      done_count++;
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    check(r, exp);
  endtask : rd_chk
  // poll status until the sequencer and busy are both quiet
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0, 4'hf);
      n++;
    end while ((r[2] !== 1'b0 || r[0] !== 1'b0) && n < 60);
    if (r[2] !== 1'b0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_idle
  task automatic wait_busy();
    int n;
    n = 0;
    while (lnk.busy !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (lnk.busy !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_busy
  task automatic cfg(input logic pd);
    @(posedge clk_i);
    cfg_wr <= 1'b1;
    cfg_pd <= pd;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
  endtask : cfg
  function automatic logic [31:0] coded(input logic [13:0] s, input logic b);
    return b ? {18'h0, s} : {18'h0, ~s[13], s[12:0]};
  endfunction : coded
  // main sequence; sections end with a one-line note
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(REG_STATUS, 32'h0);
    rd_chk(REG_RESULT, 32'h0);
    check({31'h0, lnk.data_oe}, 32'h0);
    wr(8'h0c, 32'hff);
    rd_chk(8'h0c, 32'h0);
    wb(1'b1, REG_CTRL, 32'h08, 4'he);
    rd_chk(REG_CTRL, 32'h0);
    $display("done reset and map");
    imp <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      smp <= 14'h2a5c + 14'(c);
      wr(REG_CTRL, {29'h0, c[0], 2'b01});
      wait_idle();
      rd_chk(REG_RESULT, coded(14'h2a5c + 14'(c), c[0]));
      rd_chk(REG_STATUS, 32'h2);
      check({31'h0, lowp}, 32'h1);
      wr(REG_STATUS, 32'h2);
      rd_chk(REG_STATUS, 32'h0);
    end
    $display("done codings");
    imp <= 1'b0;
    smp <= 14'h1234;
    wr(REG_CTRL, 32'h05);
    wait_busy();
    wr(REG_CTRL, 32'h0c);
    wait_idle();
    rd_chk(REG_RESULT, 32'h1234);
    check({31'h0, lowp}, 32'h1);
    smp <= 14'h0777;
    wr(REG_CTRL, 32'h0d);
    wait_idle();
    rd_chk(REG_RESULT, 32'h1234);
    $display("done power down pin");
    smp <= 14'h3fff;
    wr(REG_CTRL, 32'h05);
    wait_busy();
    wr(REG_CTRL, 32'h14);
    repeat (6) @(posedge clk_i);
    check({30'h0, lnk.busy, lnk.data_oe}, 32'h0);
    wr(REG_CTRL, 32'h04);
    repeat (6) @(posedge clk_i);
    check({18'h0, lnk.data_out}, 32'h0);
    wait_idle();
    cfg(1'b1);
    wr(REG_CTRL, 32'h05);
    wait_idle();
    check({18'h0, lnk.data_out}, 32'h0);
    wr(REG_CTRL, 32'h14);
    repeat (6) @(posedge clk_i);
    wr(REG_CTRL, 32'h05);
    wait_idle();
    rd_chk(REG_RESULT, 32'h3fff);
    $display("done reset pin and config");
    smp <= 14'h0123;
    wr(REG_CTRL, 32'h07);
    wait_idle();
    check({31'h0, lnk.data_oe}, 32'h1);
    check({18'h0, lnk.data_bus}, 32'h0123);
    smp <= 14'h0321;
    wr(REG_CTRL, 32'h07);
    wait_idle();
    check({18'h0, lnk.data_bus}, 32'h0321);
    wr(REG_CTRL, 32'h86);
    repeat (6) @(posedge clk_i);
    check({30'h0, lnk.data_oe, ser}, 32'h1);
    wr(REG_CTRL, 32'h06);
    repeat (6) @(posedge clk_i);
    check({31'h0, lnk.data_oe}, 32'h1);
    $display("done master and serial");
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, {25'h0, i[1:0], 5'h04});
      repeat (6) @(posedge clk_i);
      check({31'h0, ref_en}, {31'h0, !i[0]});
      check({31'h0, buf_en}, {31'h0, !i[1]});
      check({31'h0, temp_en}, {31'h0, i == 0});
    end
    $display("done reference controls");
    check(done_count, 32'd6);
    tally_and_finish();
  end
endmodule : adc_conversion_parallel_read_tb
`default_nettype wire
